// file: cds_clock_control.sv
// Notes on behaviour
// R01: core clock feeds register file, status, stack; stopping it halts the core.
// R02: peripheral clock feeds timers, SPI, serial port and interrupt unit.
// R03: selected interrupt inputs are caught even while peripheral clock stops.
// R04: power-reduction bits gate fast SPI, card, USB device and host clocks.
// R05: memory read clock runs together with the core clock.
// R06: memory write clock comes from its own oscillator, not the core.
// R07: async timer clock runs from its own source, also during sleep.
// R08: fast SPI clock divided from the root clock, not the core clock.
// R09: card clock divided from root clock, never above 12 MHz.
// R10: USB clocks only when root is PLL, divided by two.
// R11: root clock selects the crystal input at start-up.
// R12: source type fuse 1 selects crystal, 0 selects external clock.
// R13: blank fuses give crystal, longest start-up and time-out enabled.
// R14: clearing the PLL select bit returns the root clock to crystal.
// R15: internal time-out starts only after all other reset sources release.
// R16: time-out is 0, 512 or 8192 watchdog cycles chosen by fuses.
// R17: a counter on the oscillator holds reset for the start-up count.
// R18: start-up count depends on clock type, 6 up to many thousand cycles.
// R19: reset uses time-out plus start-up; wake from sleep only start-up.
// R20: PLL enable starts locking; lock status set once the clock is stable.
// R21: software selects the PLL only after lock status is set.
// R22: root clock switches without truncated or merged pulses.
`timescale 1ns/100ps
`default_nettype none
module cds_clock_control #(
  parameter int                TIMEOUT_LONG   = 8192,
  parameter int                STARTUP_XTAL   = 16384,
  parameter int                IRQ_W          = 4,
  parameter logic [IRQ_W-1:0]  ASYNC_IRQ_MASK = 4'h3
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      resetSrc_n,
  input  wire logic                      crystalPin,
  input  wire logic                      wdtOscPin,
  input  wire logic                      rcOscPin,
  input  wire logic                      asyncTimerPin,
  input  wire logic                      pllLockPin,
  input  wire logic [IRQ_W-1:0]          extIrqPin,
  input  wire logic                      pllTick,
  input  wire logic                      fuseBlank,
  input  wire logic [3:0]                clockSelectFuses,
  input  wire logic [1:0]                startupTimeFuses,
  input  wire logic                      pllEnable,
  input  wire logic                      pllSelect,
  input  wire logic                      idleSleep,
  input  wire logic                      deepSleep,
  input  wire logic                      prFastSpi,
  input  wire logic                      prCardIface,
  input  wire logic                      prUsbDevice,
  input  wire logic                      prUsbHost,
  input  wire logic [cds_pkg::DIV_W-1:0] fastSpiDiv,
  input  wire logic [cds_pkg::DIV_W-1:0] cardDiv,
  input  wire logic [IRQ_W-1:0]          irqClear,
  output logic                           internalReset_n,
  output logic                           rootMuxClock,
  output logic                           rootIsPll,
  output logic                           pllLocked,
  output logic                           coreDomainClock,
  output logic                           memoryReadClock,
  output logic                           peripheralClock,
  output logic                           memoryWriteClock,
  output logic                           asyncTimerClock,
  output logic                           fastSpiClock,
  output logic                           cardIfaceClock,
  output logic                           usbDeviceClock,
  output logic                           usbHostClock,
  output logic [IRQ_W-1:0]               irqPending
);
  localparam int SW = 6 + IRQ_W;
  localparam int CW = cds_pkg::CNT_W;
  localparam int DW = cds_pkg::DIV_W;

  if (TIMEOUT_LONG < 1 || TIMEOUT_LONG >= (1 << CW)) begin : g_badTout
    $error("TIMEOUT_LONG out of counter range");
  end
  if (STARTUP_XTAL < 1 || STARTUP_XTAL >= (1 << CW)) begin : g_badStup
    $error("STARTUP_XTAL out of counter range");
  end

  // pins cross into clk_sys; stage C only feeds edge detection
  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  logic [SW-1:0] syncC;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end
    else
    begin
      syncA <= {resetSrc_n, crystalPin, wdtOscPin, rcOscPin,
                asyncTimerPin, pllLockPin, extIrqPin};
      syncB <= syncA;
      syncC <= syncB;
    end

  logic             resetOk;
  logic             xtalTick;
  logic             wdtTick;
  logic             rcTick;
  logic             asyncTick;
  logic             lockSync;
  logic [IRQ_W-1:0] irqEdge;
  assign resetOk   = syncB[SW-1];
  assign xtalTick  = syncB[SW-2] & ~syncC[SW-2];
  assign wdtTick   = syncB[SW-3] & ~syncC[SW-3];
  assign rcTick    = syncB[SW-4] & ~syncC[SW-4];
  assign asyncTick = syncB[SW-5] & ~syncC[SW-5];
  assign lockSync  = syncB[SW-6];
  assign irqEdge   = syncB[IRQ_W-1:0] & ~syncC[IRQ_W-1:0];

  function automatic logic [CW-1:0] f_timeout(
    input logic [3:0] ck,
    input logic [1:0] sut
  );
    logic [2:0] code;
    code = {ck[0], sut};
    if (ck[cds_pkg::SRC_TYPE_BIT] == cds_pkg::SRC_EXTERNAL)
      f_timeout = (sut == 2'h0) ? cds_pkg::TOUT_NONE :         // R16
                  (sut == 2'h1) ? cds_pkg::TOUT_SHORT : CW'(TIMEOUT_LONG);
    else if (code == 3'h2 || code == 3'h5)
      f_timeout = cds_pkg::TOUT_NONE;
    else if (code == 3'h0 || code == 3'h3 || code == 3'h6)
      f_timeout = cds_pkg::TOUT_SHORT;
    else
      f_timeout = CW'(TIMEOUT_LONG);
  endfunction

  function automatic logic [CW-1:0] f_startup(
    input logic [3:0] ck,
    input logic [1:0] sut
  );
    logic [2:0] code;
    code = {ck[0], sut};
    if (ck[cds_pkg::SRC_TYPE_BIT] == cds_pkg::SRC_EXTERNAL)   // R12
      f_startup = cds_pkg::STUP_EXT;                           // R18
    else if (code <= 3'h1)
      f_startup = cds_pkg::STUP_RES_S;
    else if (code <= 3'h4)
      f_startup = cds_pkg::STUP_RES_L;
    else
      f_startup = CW'(STARTUP_XTAL);
  endfunction

  cds_pkg::cds_rst_e stState;
  logic [CW-1:0]     cnt;
  logic              fromReset;

  // fuses are read while held in reset; blank array means ship setup
  logic [3:0]    effCksel;
  logic [1:0]    effSut;
  logic [CW-1:0] toutTarget;
  logic [CW-1:0] stupTarget;
  assign effCksel = fuseBlank ? cds_pkg::SHIP_CKSEL : clockSelectFuses; // R13
  assign effSut   = fuseBlank ? cds_pkg::SHIP_SUT : startupTimeFuses;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      toutTarget <= '0;
      stupTarget <= '0;
    end
    else if (stState == cds_pkg::ST_HOLD)
    begin
      toutTarget <= f_timeout(effCksel, effSut);
      stupTarget <= f_startup(effCksel, effSut);
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      stState   <= cds_pkg::ST_HOLD;
      cnt       <= '0;
      fromReset <= 1'b1;
    end
    else if (!resetOk)
    begin
      stState   <= cds_pkg::ST_HOLD;                           // R15
      cnt       <= '0;
      fromReset <= 1'b1;
    end
    else
      unique case (stState)
        cds_pkg::ST_HOLD:
        begin
          stState <= cds_pkg::ST_TIMEOUT;
          cnt     <= '0;
        end
        cds_pkg::ST_TIMEOUT:
          if (cnt == toutTarget)
          begin
            stState <= cds_pkg::ST_STARTUP;                    // R19
            cnt     <= '0;
          end
          else if (wdtTick)
            cnt <= cnt + 1'b1;                                 // R16
        cds_pkg::ST_STARTUP:
          if (cnt == stupTarget)
          begin
            stState   <= cds_pkg::ST_RUN;                      // R17
            fromReset <= 1'b0;
          end
          else if (xtalTick)
            cnt <= cnt + 1'b1;                                 // R17
        cds_pkg::ST_RUN:
          if (deepSleep)
            stState <= cds_pkg::ST_SLEEP;
        cds_pkg::ST_SLEEP:
          if (!deepSleep)
          begin
            stState <= cds_pkg::ST_STARTUP;                    // R19
            cnt     <= '0;
          end
      endcase

  // reset stays low through start-up only on the path from a reset
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      internalReset_n <= 1'b0;
    else if (!resetOk)
      internalReset_n <= 1'b0;                                 // R15
    else if (fromReset && stState == cds_pkg::ST_STARTUP &&
             cnt == stupTarget)
      internalReset_n <= 1'b1;                                 // R17

  // root mux: each switch leaves a gap until the new source's next edge
  cds_pkg::cds_mux_e muxState;
  logic              rootTick;
  always_comb
  begin
    rootTick = 1'b0;
    unique case (muxState)
      cds_pkg::MX_XTAL:    rootTick = xtalTick;
      cds_pkg::MX_PLL:     rootTick = pllTick;
      cds_pkg::MX_TO_PLL:  rootTick = 1'b0;                    // R22
      cds_pkg::MX_TO_XTAL: rootTick = 1'b0;                    // R22
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      muxState <= cds_pkg::MX_XTAL;                            // R11
    else
      unique case (muxState)
        cds_pkg::MX_XTAL:
          if (pllSelect && xtalTick)
            muxState <= cds_pkg::MX_TO_PLL;
        cds_pkg::MX_TO_PLL:
          if (!pllSelect)
            muxState <= cds_pkg::MX_XTAL;
          else if (pllTick)
            muxState <= cds_pkg::MX_PLL;
        cds_pkg::MX_PLL:
          if (!pllSelect && pllTick)
            muxState <= cds_pkg::MX_TO_XTAL;                   // R14
        cds_pkg::MX_TO_XTAL:
          if (xtalTick)
            muxState <= cds_pkg::MX_XTAL;                      // R14
      endcase

  logic running;
  logic coreGo;
  assign running = resetOk && stState == cds_pkg::ST_RUN;
  assign coreGo  = running && !idleSleep;

  // dividers count root edges; card ratio clamped on the fast source
  logic [DW-1:0] spiCnt;
  logic [DW-1:0] cardCnt;
  logic [DW-1:0] cardSet;
  logic          usbPhase;
  logic          spiFire;
  logic          cardFire;
  logic          usbFire;
  assign cardSet  = (muxState == cds_pkg::MX_PLL &&
                     cardDiv < cds_pkg::CARD_MIN_SET) ?
                    cds_pkg::CARD_MIN_SET : cardDiv;           // R09
  assign spiFire  = rootTick && running && spiCnt >= fastSpiDiv;
  assign cardFire = rootTick && running && cardCnt >= cardSet;
  assign usbFire  = rootTick && running && usbPhase &&
                    muxState == cds_pkg::MX_PLL;               // R10

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      spiCnt   <= '0;
      cardCnt  <= '0;
      usbPhase <= 1'b0;
    end
    else if (rootTick && running)
    begin
      spiCnt   <= spiFire ? '0 : spiCnt + 1'b1;                // R08
      cardCnt  <= cardFire ? '0 : cardCnt + 1'b1;              // R09
      usbPhase <= (muxState == cds_pkg::MX_PLL) && !usbPhase;  // R10
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      pllLocked <= 1'b0;
    else
      pllLocked <= pllEnable && lockSync;                      // R20

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rootMuxClock     <= 1'b0;
      rootIsPll        <= 1'b0;
      coreDomainClock  <= 1'b0;
      memoryReadClock  <= 1'b0;
      peripheralClock  <= 1'b0;
      memoryWriteClock <= 1'b0;
      asyncTimerClock  <= 1'b0;
      fastSpiClock     <= 1'b0;
      cardIfaceClock   <= 1'b0;
      usbDeviceClock   <= 1'b0;
      usbHostClock     <= 1'b0;
    end
    else
    begin
      rootMuxClock     <= rootTick && stState != cds_pkg::ST_SLEEP;
      rootIsPll        <= muxState == cds_pkg::MX_PLL;
      coreDomainClock  <= rootTick && coreGo;                  // R01
      memoryReadClock  <= rootTick && coreGo;                  // R05
      peripheralClock  <= rootTick && running;                 // R02
      memoryWriteClock <= rcTick && running;                   // R06
      asyncTimerClock  <= asyncTick;                           // R07
      fastSpiClock     <= spiFire && !prFastSpi;               // R04
      cardIfaceClock   <= cardFire && !prCardIface;            // R04
      usbDeviceClock   <= usbFire && !prUsbDevice;             // R04
      usbHostClock     <= usbFire && !prUsbHost;               // R04
    end

  // async inputs latch with clocks stopped; a new edge beats a clear
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    logic caught;
    assign caught = irqEdge[i] && (ASYNC_IRQ_MASK[i] || running); // R03
    always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
        irqPending[i] <= 1'b0;
      else if (caught)
        irqPending[i] <= 1'b1;                                 // R03
      else if (irqClear[i])
        irqPending[i] <= 1'b0;
  end

  sequence s_toutDone;
    stState == cds_pkg::ST_TIMEOUT && cnt == toutTarget && resetOk;
  endsequence
  sequence s_wake;
    stState == cds_pkg::ST_SLEEP && !deepSleep && resetOk;
  endsequence

  property p_coreInReset;
    @(posedge clk_sys) disable iff (!rst_n)
      !internalReset_n |-> !coreDomainClock;
  endproperty
  a_coreInReset: assert property (p_coreInReset) // R01
    else $error("core clock while internal reset");
  property p_readWithCore;
    @(posedge clk_sys) disable iff (!rst_n)
      memoryReadClock == coreDomainClock;
  endproperty
  a_readWithCore: assert property (p_readWithCore) // R05
    else $error("memory read clock differs from core clock");
  property p_gateSpi;
    @(posedge clk_sys) disable iff (!rst_n)
      fastSpiClock |-> !$past(prFastSpi);
  endproperty
  a_gateSpi: assert property (p_gateSpi) // R04
    else $error("fast spi clock while gated");
  property p_usbPll;
    @(posedge clk_sys) disable iff (!rst_n)
      (usbDeviceClock || usbHostClock) |-> rootIsPll ##1 !usbDeviceClock;
  endproperty
  a_usbPll: assert property (p_usbPll) // R10
    else $error("usb clock without pll or faster than half");
  property p_asyncRuns;
    @(posedge clk_sys) disable iff (!rst_n)
      asyncTimerClock == $past(asyncTick);
  endproperty
  a_asyncRuns: assert property (p_asyncRuns) // R07
    else $error("async timer clock lost");
  property p_backToXtal;
    @(posedge clk_sys) disable iff (!rst_n)
      (rootIsPll && !pllSelect) |-> ##[1:100] !rootIsPll;
  endproperty
  a_backToXtal: assert property (p_backToXtal) // R14
    else $error("root clock stuck on pll");
  property p_gapOnSwitch;
    @(posedge clk_sys) disable iff (!rst_n)
      (muxState == cds_pkg::MX_TO_PLL || muxState == cds_pkg::MX_TO_XTAL)
        |=> !rootMuxClock;
  endproperty
  a_gapOnSwitch: assert property (p_gapOnSwitch) // R22
    else $error("root pulse during source switch");
  property p_lockNeedsEnable;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(pllLocked) |-> $past(pllEnable);
  endproperty
  a_lockNeedsEnable: assert property (p_lockNeedsEnable) // R20
    else $error("lock without pll enable");
  property p_releaseAfterStartup;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(internalReset_n) |-> $past(stState == cds_pkg::ST_STARTUP);
  endproperty
  a_releaseAfterStartup: assert property (p_releaseAfterStartup) // R17
    else $error("reset released outside start-up");
  property p_toutToStartup;
    @(posedge clk_sys) disable iff (!rst_n)
      s_toutDone |=> stState == cds_pkg::ST_STARTUP && cnt == '0;
  endproperty
  a_toutToStartup: assert property (p_toutToStartup) // R16
    else $error("time-out end not followed by start-up");
  property p_wakeNoReset;
    @(posedge clk_sys) disable iff (!rst_n)
      s_wake |=> stState == cds_pkg::ST_STARTUP && internalReset_n;
  endproperty
  a_wakeNoReset: assert property (p_wakeNoReset) // R19
    else $error("wake applied reset time-out");
  property p_srcHolds;
    @(posedge clk_sys) disable iff (!rst_n)
      !resetSrc_n ##3 !resetSrc_n |=> !internalReset_n;
  endproperty
  a_srcHolds: assert property (p_srcHolds) // R15
    else $error("internal reset free while source asserted");
endmodule // cds_clock_control
`default_nettype wire

// file: cds_clock_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s exp %0d got %0d", nm, e, g); \
    end \
  end
module cds_clock_control_tb;
  logic       clk_sys = 1'b0, rst_n = 1'b0, resetSrc_n = 1'b0;
  logic       fuseBlank = 1'b1, pllEnable = 1'b0, pllSelect = 1'b0;
  logic       idleSleep = 1'b0, deepSleep = 1'b0, prFastSpi = 1'b0;
  logic       prCardIface = 1'b0, prUsbDevice = 1'b0, prUsbHost = 1'b0;
  logic [3:0] cksel = 4'hF, extIrq = 4'h0, irqClr = 4'h0;
  logic [3:0] spiDiv = 4'h3, cardDiv = 4'h1;
  logic [1:0] sut = 2'h3;
  wire logic  xtal, wdt, rc, asy, lockPin, pllTick;
  wire logic  internalReset_n, rootMuxClock, rootIsPll, pllLocked;
  wire logic  coreDomainClock, memoryReadClock, peripheralClock;
  wire logic  memoryWriteClock, asyncTimerClock, fastSpiClock;
  wire logic  cardIfaceClock, usbDeviceClock, usbHostClock;
  wire logic [3:0] irqPending;
  wire logic [9:0] pulses;
  int         cnt [10];
  int         miscompares = 0, comparisons = 0, cyc = 0, b2b = 0;
  logic       clr = 1'b0, prevRoot = 1'b0;

  assign pulses = {usbHostClock, usbDeviceClock, cardIfaceClock,
                   fastSpiClock, asyncTimerClock, memoryWriteClock,
                   peripheralClock, memoryReadClock, coreDomainClock,
                   rootMuxClock};

  cds_osc_model i_cds_osc_model (
    .clk_sys(clk_sys), .pllEnable(pllEnable), .crystalPin(xtal),
    .wdtOscPin(wdt), .rcOscPin(rc), .asyncTimerPin(asy),
    .pllLockPin(lockPin), .pllTick(pllTick)
  );

  cds_clock_control #(.TIMEOUT_LONG(8), .STARTUP_XTAL(10))
  i_cds_clock_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .resetSrc_n(resetSrc_n),
    .crystalPin(xtal), .wdtOscPin(wdt), .rcOscPin(rc),
    .asyncTimerPin(asy), .pllLockPin(lockPin), .extIrqPin(extIrq),
    .pllTick(pllTick), .fuseBlank(fuseBlank), .clockSelectFuses(cksel),
    .startupTimeFuses(sut), .pllEnable(pllEnable), .pllSelect(pllSelect),
    .idleSleep(idleSleep), .deepSleep(deepSleep), .prFastSpi(prFastSpi),
    .prCardIface(prCardIface), .prUsbDevice(prUsbDevice),
    .prUsbHost(prUsbHost), .fastSpiDiv(spiDiv), .cardDiv(cardDiv),
    .irqClear(irqClr), .internalReset_n(internalReset_n),
    .rootMuxClock(rootMuxClock), .rootIsPll(rootIsPll),
    .pllLocked(pllLocked), .coreDomainClock(coreDomainClock),
    .memoryReadClock(memoryReadClock), .peripheralClock(peripheralClock),
    .memoryWriteClock(memoryWriteClock),
    .asyncTimerClock(asyncTimerClock), .fastSpiClock(fastSpiClock),
    .cardIfaceClock(cardIfaceClock), .usbDeviceClock(usbDeviceClock),
    .usbHostClock(usbHostClock), .irqPending(irqPending)
  );

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // pulse counters per domain; back-to-back root pulses mean a glitch
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 10; i++)
      cnt[i] <= clr ? 0 : cnt[i] + int'(pulses[i] === 1'b1);
    prevRoot <= rootMuxClock;
    if (rootMuxClock === 1'b1 && prevRoot === 1'b1)
      b2b <= b2b + 1;
  end

  function automatic logic near(input int a, input int b);
    return (a >= b - 2) && (a <= b + 2);
  endfunction

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  // count pulses over n root ticks, bounded
  task automatic window(input int n);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    cyc = 0;
    while (cnt[0] < n && cyc < 5000)
    begin
      tick();
      cyc++;
    end
  endtask

  task automatic t_reset(input logic b, input logic [3:0] ck,
                         input logic [1:0] su, input int to, input int st);
    int lo;
    int n;
    lo = (to > 0 ? (to - 1) * 20 : 0) + (st - 1) * 12;
    n = 0;
    rst_n = 1'b0;
    resetSrc_n = 1'b0;
    fuseBlank = b;
    cksel = ck;
    sut = su;
    repeat (8) tick();
    rst_n = 1'b1;
    // time-out must not start while another source still holds reset
    repeat (300) tick();
    `CHK("held", 1'b0, internalReset_n)
    resetSrc_n = 1'b1;
    while (internalReset_n !== 1'b1 && n < lo + 200)
    begin
      tick();
      n++;
    end
    `CHK("delay", 1'b1, n >= lo && n <= to * 20 + st * 12 + 45)
  endtask

  task automatic t_domains();
    window(48);
    `CHK("xtal rate", 1'b1, cyc > 540 && cyc < 610)
    `CHK("root", 1'b0, rootIsPll)
    `CHK("core", 1'b1, near(cnt[1], 48))
    `CHK("mread", 1'b1, near(cnt[2], 48))
    `CHK("periph", 1'b1, near(cnt[3], 48))
    `CHK("spi", 1'b1, near(cnt[6], 12))
    `CHK("card", 1'b1, near(cnt[7], 24))
    `CHK("usb xtal", 0, cnt[8] + cnt[9])
    prFastSpi = 1'b1;
    prCardIface = 1'b1;
    window(24);
    `CHK("spi gated", 0, cnt[6])
    `CHK("card gated", 0, cnt[7])
    prFastSpi = 1'b0;
    prCardIface = 1'b0;
    idleSleep = 1'b1;
    window(24);
    `CHK("idle core", 0, cnt[1] + cnt[2])
    `CHK("idle periph", 1'b1, near(cnt[3], 24))
    `CHK("mwrite", 1'b1, cnt[4] > 10)
    idleSleep = 1'b0;
  endtask

  task automatic t_sleep();
    int n;
    logic fell;
    fell = 1'b0;
    deepSleep = 1'b1;
    // pulses launched on the edge that enters sleep are not counted
    tick();
    clr = 1'b1;
    tick();
    clr = 1'b0;
    repeat (100) tick();
    extIrq = 4'h5;
    repeat (5) tick();
    extIrq = 4'h0;
    repeat (300) tick();
    `CHK("async", 1'b1, near(cnt[5], 4))
    `CHK("sleep core", 0, cnt[1] + cnt[3])
    `CHK("irq sleep", 4'h1, irqPending)
    deepSleep = 1'b0;
    n = 0;
    while (coreDomainClock !== 1'b1 && n < 400)
    begin
      tick();
      n++;
      fell |= (internalReset_n !== 1'b1);
    end
    `CHK("wake", 1'b1, n >= 100 && n < 200)
    `CHK("no reset", 1'b0, fell)
    extIrq = 4'h4;
    repeat (5) tick();
    extIrq = 4'h0;
    `CHK("irq run", 4'h5, irqPending)
    irqClr = 4'hF;
    tick();
    irqClr = 4'h0;
    repeat (3) tick();
    `CHK("irq clr", 4'h0, irqPending)
  endtask

  task automatic t_pll();
    int n;
    pllEnable = 1'b1;
    tick();
    `CHK("unlocked", 1'b0, pllLocked)
    n = 0;
    while (pllLocked !== 1'b1 && n < 400)
    begin
      tick();
      n++;
    end
    `CHK("locked", 1'b1, pllLocked)
    pllSelect = 1'b1;
    n = 0;
    while (rootIsPll !== 1'b1 && n < 100)
    begin
      tick();
      n++;
    end
    `CHK("to pll", 1'b1, rootIsPll)
    window(64);
    `CHK("pll rate", 1'b1, near(cyc, 128))
    `CHK("usbdev", 1'b1, near(cnt[8], 32))
    `CHK("usbhost", 1'b1, near(cnt[9], 32))
    `CHK("card clamp", 1'b1, near(cnt[7], 8))
    `CHK("spi pll", 1'b1, near(cnt[6], 16))
    prUsbHost = 1'b1;
    window(32);
    `CHK("host gated", 0, cnt[9])
    `CHK("dev alone", 1'b1, near(cnt[8], 16))
    pllSelect = 1'b0;
    n = 0;
    while (rootIsPll !== 1'b0 && n < 100)
    begin
      tick();
      n++;
    end
    `CHK("to xtal", 1'b0, rootIsPll)
    window(16);
    `CHK("usb off", 0, cnt[8])
    `CHK("glitch", 0, b2b)
    pllEnable = 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #600000;
    miscompares++;
    results();
  end

  initial
  begin
    t_reset(1'b0, 4'h0, 2'h0, 0, 6);
    t_reset(1'b0, 4'h0, 2'h1, 512, 6);
    t_reset(1'b0, 4'hE, 2'h0, 512, 258);
    t_reset(1'b0, 4'hF, 2'h1, 0, 10);
    t_reset(1'b0, 4'hE, 2'h2, 0, 1024);
    t_reset(1'b1, 4'h0, 2'h0, 8, 10);
    t_domains();
    t_sleep();
    t_pll();
    results();
  end
endmodule // cds_clock_control_tb
`default_nettype wire

// file: cds_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module cds_osc_model (
  input  wire logic clk_sys,
  input  wire logic pllEnable,
  output logic      crystalPin,
  output logic      wdtOscPin,
  output logic      rcOscPin,
  output logic      asyncTimerPin,
  output logic      pllLockPin,
  output logic      pllTick
);
  initial
  begin
    crystalPin    = 1'b0;
    wdtOscPin     = 1'b0;
    rcOscPin      = 1'b0;
    asyncTimerPin = 1'b0;
    pllLockPin    = 1'b0;
    pllTick       = 1'b0;
  end

  // free-running sources, periods whole multiples of the clk_sys period
  always #60 crystalPin = ~crystalPin;
  always #100 wdtOscPin = ~wdtOscPin;
  always #70 rcOscPin = ~rcOscPin;
  always #500 asyncTimerPin = ~asyncTimerPin;

  // lock settles 2 us after enable and drops at once on disable
  always @(posedge pllEnable)
  begin
    #2000;
    pllLockPin = pllEnable;
  end
  always @(negedge pllEnable) pllLockPin = 1'b0;

  // one pulse per pll edge, every other sys cycle, only once locked
  always @(posedge clk_sys) pllTick <= #1 pllLockPin & ~pllTick;
endmodule // cds_osc_model
`default_nettype wire

// file: cds_pkg.sv
`default_nettype none
package cds_pkg;
  localparam int CNT_W = 16;
  localparam int DIV_W = 4;

  typedef enum logic [4:0] {
    ST_HOLD    = 5'h01,
    ST_TIMEOUT = 5'h02,
    ST_STARTUP = 5'h04,
    ST_RUN     = 5'h08,
    ST_SLEEP   = 5'h10
  } cds_rst_e;

  typedef enum logic [3:0] {
    MX_XTAL    = 4'h1,
    MX_TO_PLL  = 4'h2,
    MX_PLL     = 4'h4,
    MX_TO_XTAL = 4'h8
  } cds_mux_e;

  // clock select fuses, 1 = unprogrammed
  localparam logic [3:0] SHIP_CKSEL   = 4'hF;
  localparam logic [1:0] SHIP_SUT     = 2'h3;
  localparam logic       SRC_EXTERNAL = 1'h0;
  localparam int         SRC_TYPE_BIT = 3;

  // watchdog oscillator cycles of reset time-out
  localparam logic [CNT_W-1:0] TOUT_NONE  = 16'h0000;
  localparam logic [CNT_W-1:0] TOUT_SHORT = 16'h0200;
  // oscillator start-up cycles
  localparam logic [CNT_W-1:0] STUP_EXT   = 16'h0006;
  localparam logic [CNT_W-1:0] STUP_RES_S = 16'h0102;
  localparam logic [CNT_W-1:0] STUP_RES_L = 16'h0400;

  localparam int PLL_KHZ      = 96000;
  localparam int CARD_MAX_KHZ = 12000;
  localparam int CARD_MIN_DIV = (PLL_KHZ + CARD_MAX_KHZ - 1) / CARD_MAX_KHZ;
  localparam logic [DIV_W-1:0] CARD_MIN_SET = DIV_W'(CARD_MIN_DIV - 1);
endpackage
`default_nettype wire
